// ---- nco_edge_sync.sv ----
// Two-flop synchroniser with rising-edge detection, one lane per input.
// Assumes inputs are asynchronous to clk_sys and slower than half its rate.
`timescale 1ns/1ns
`default_nettype none

module nco_edge_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] rise
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stable_q;
   logic [WIDTH-1:0] prev_q;

   // Only the second flop and the delayed copy feed the edge detector.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_q   <= '0;
         stable_q <= '0;
         prev_q   <= '0;
      end else begin
         meta_q   <= asyncIn;
         stable_q <= meta_q;
         prev_q   <= stable_q;
      end
   end

   assign rise = stable_q & ~prev_q;

endmodule : nco_edge_sync

`default_nettype wire

// ---- nco_pkg.sv ----
// Register map, field positions, types and timing for the numeric oscillator.
// Assumes a 32-bit AXI4-Lite bus with byte addresses, one register a word.
`default_nettype none

package nco_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int ACC_W  = 20;
   localparam int INC_W  = 16;
   localparam int ACCU_W = 4;
   localparam int PWS_W  = 3;
   localparam int PCNT_W = 8;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CONTROL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CLOCK_SEL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ACC_LOW   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ACC_HIGH  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_ACC_UPPER = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_INC_LOW   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_INC_HIGH  = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ       = 8'h1C;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CON_ON_BIT   = 7;
   localparam int CON_OE_BIT   = 6;
   localparam int CON_OUT_BIT  = 5;
   localparam int CON_POL_BIT  = 4;
   localparam int CON_PFM_BIT  = 0;
   localparam int CLK_PWS_LSB  = 5;
   localparam int CLK_CKS_LSB  = 0;
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_EN_BIT   = 1;
   localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;

   // Input clock edges between a low-byte write and the buffer load.
   localparam logic [1:0] INC_LOAD_EDGES = 2'h2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CK_FAST_OSC,
      CK_SYSTEM,
      CK_LOGIC_CELL,
      CK_EXT_PIN
   } clk_src_t;

   typedef struct packed {
      logic moduleOn;
      logic pinDriveEnable;
      logic outputInvert;
      logic pulseModeSelect;
   } control_t;

   typedef struct packed {
      logic [PWS_W-1:0] pulseWidthSelect;
      clk_src_t         inputClockSelect;
   } clock_cfg_t;

endpackage : nco_pkg

`default_nettype wire

// ---- nco_props.sv ----
// Bus and output checks for the numeric oscillator.
// Sees only top-level ports; bound from the testbench top file.
`timescale 1ns/1ns
`default_nettype none

module nco_props (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        awready,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic        oscOutput,
   input wire logic        pinOut,
   input wire logic        irqRequest,
   input wire logic        peripheralIrqEnable,
   input wire logic        globalIrqEnable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_pin_mirror: assert property (pinOut == oscOutput)
      else $error("pin differs from output");
   a_irq_gated: assert property (
      irqRequest |-> $past(peripheralIrqEnable && globalIrqEnable))
      else $error("request without enables");
   a_irq_drop: assert property (!globalIrqEnable |=> !irqRequest)
      else $error("request kept after global disable");
   a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_wr_blocked: assert property (bvalid |-> !awready && !wready)
      else $error("write ready during response");
   a_rd_blocked: assert property (rvalid |-> !arready)
      else $error("read ready during response");
   a_b_done: assert property (bvalid && bready |=> !bvalid && awready)
      else $error("write response not retired");
   a_r_done: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read response not retired");

   cover property ($rose(oscOutput));
   cover property ($rose(irqRequest));
   cover property (bvalid && bready);
endmodule : nco_props

`default_nettype wire

// ---- nco_sink.sv ----
// Consumer of the oscillator output: measures period and high time.
// Assumes the output is a registered level in the clk_sys domain.
`timescale 1ns/1ns
`default_nettype none

module nco_sink (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        oscOutput,
   input  wire logic        pinOut,
   input  wire logic        pinOutEnable,
   output logic      [15:0] riseCnt,
   output logic      [15:0] periodQ,
   output logic      [15:0] highQ,
   output logic             pinLevel
);
   logic        prev_q;
   logic        lastPin_q;
   logic [15:0] since_q;
   logic [15:0] hiRun_q;

   // An undriven pin has no keeper, so show the opposite of its last level.
   assign pinLevel = pinOutEnable ? pinOut : ~lastPin_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         {prev_q, lastPin_q, riseCnt, periodQ} <= '0;
         {since_q, hiRun_q, highQ} <= '0;
      end else begin
         prev_q <= oscOutput;
         if (pinOutEnable) lastPin_q <= pinOut;
         if (oscOutput && !prev_q) begin
            riseCnt <= riseCnt + 16'h1;
            periodQ <= since_q;
            since_q <= 16'h1;
         end else since_q <= since_q + 16'h1;
         if (oscOutput) hiRun_q <= hiRun_q + 16'h1;
         else begin
            if (prev_q) highQ <= hiRun_q;
            hiRun_q <= 16'h0;
         end
      end
   end
endmodule : nco_sink

`default_nettype wire

// ---- numeric_oscillator.sv ----
// Numerically controlled oscillator with an AXI4-Lite register slave.
// Assumes fast osc, logic cell and pin sources are slower than half of clk_sys (system clock steps every cycle); they are
// sampled as ordinary inputs and their rising edges advance the adder.
//
// Contract
// - A 20-bit accumulator is read and written as three byte registers.
// - Each selected input clock rising edge adds the buffered increment.
// - The adder carry out is the raw overflow event.
// - The 16-bit increment comes from low and high byte registers.
// - Enabled: increment buffer loads on second input edge after low write.
// - Disabled: increment buffer loads right after any increment write.
// - Increment is double buffered; the buffer is hidden from software.
// - Toggle mode flips the output on every overflow.
// - Control bit 0 selects pulse mode when one, toggle mode when zero.
// - Pulse mode drives output active at overflow for the chosen width.
// - Width code n gives two to the n input clock periods.
// - Width applies in pulse mode only; software keeps it short.
// - Clock select: fast osc, system clock, logic cell, external pin.
// - Control bit 4 inverts the output as the last stage.
// - A polarity change with interrupts enabled raises the flag.
// - Read-only control bit 5 shows the current output level.
// - Control bit 6 enables the pin drive.
// - Control bit 7 enables stepping, the interrupt request and the fast oscillator hold.
// - Each overflow sets a sticky flag that software clears.
// - Interrupt request needs module, local, peripheral and global enables.
// - Reset clears every register to zero.
// - Module runs in sleep; keeps fast oscillator on when it uses it.
// - Upper accumulator register holds bits 19 to 16, upper bits zero.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none

module numeric_oscillator (
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   // AXI4-Lite slave
   input  wire logic [nco_pkg::ADDR_W-1:0]   awaddr,
   input  wire logic                         awvalid,
   output logic                              awready,
   input  wire logic [nco_pkg::DATA_W-1:0]   wdata,
   input  wire logic [nco_pkg::DATA_W/8-1:0] wstrb,
   input  wire logic                         wvalid,
   output logic                              wready,
   output logic [1:0]                        bresp,
   output logic                              bvalid,
   input  wire logic                         bready,
   input  wire logic [nco_pkg::ADDR_W-1:0]   araddr,
   input  wire logic                         arvalid,
   output logic                              arready,
   output logic [nco_pkg::DATA_W-1:0]        rdata,
   output logic [1:0]                        rresp,
   output logic                              rvalid,
   input  wire logic                         rready,
   // Clock sources and system enables
   input  wire logic                         internalFastOsc,
   input  wire logic                         logicCell1Output,
   input  wire logic                         externalClockPin,
   input  wire logic                         peripheralIrqEnable,
   input  wire logic                         globalIrqEnable,
   // Consumers
   output logic                              oscOutput,
   output logic                              pinOut,
   output logic                              pinOutEnable,
   output logic                              irqRequest,
   output logic                              keepFastOscOn
);

   import nco_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   control_t          ctrl_q;
   clock_cfg_t        clkCfg_q;
   logic [ACC_W-1:0]  accumulatorValue_q;
   logic [INC_W-1:0]  incrementValue_q;
   logic [INC_W-1:0]  incBuf_q;
   logic [1:0]        loadWait_q;
   logic              loadNow_q;
   logic              toggleOut_q;
   logic              pulseActive_q;
   logic [PCNT_W-1:0] pulseCnt_q;
   logic              overflowIrqFlag_q;
   logic              overflowIrqEnable_q;
   logic              outputLevel_q;

   logic [ADDR_W-1:0] awAddr_q;
   logic              awHeld_q;
   logic [BYTE_W-1:0] wByte_q;
   logic              wLane_q;
   logic              wHeld_q;

   // ----------------------------------------------------------------
   // Input clock selection
   // ----------------------------------------------------------------
   logic [2:0] srcRise;
   logic       selEdge;
   logic       step;

   nco_edge_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .asyncIn ({externalClockPin, logicCell1Output, internalFastOsc}),
      .rise    (srcRise)
   );

   always_comb begin
      unique case (clkCfg_q.inputClockSelect)
         CK_FAST_OSC:   selEdge = srcRise[0];
         CK_SYSTEM:     selEdge = 1'b1;
         CK_LOGIC_CELL: selEdge = srcRise[1];
         CK_EXT_PIN:    selEdge = srcRise[2];
      endcase
   end

   assign step = selEdge & ctrl_q.moduleOn;

   // ----------------------------------------------------------------
   // Adder
   // ----------------------------------------------------------------
   logic [ACC_W:0] sum;
   logic           accumulatorCarry;

   assign sum = {1'b0, accumulatorValue_q} + (ACC_W+1)'(incBuf_q);
   assign accumulatorCarry = step & sum[ACC_W];

   // ----------------------------------------------------------------
   // Register write decode
   // ----------------------------------------------------------------
   logic              doWrite;
   logic              wrMapped;
   logic              wrOk;
   logic [BYTE_W-1:0] wb;

   assign doWrite  = awHeld_q & wHeld_q & ~bvalid;
   assign wrMapped = (awAddr_q[1:0] == 2'h0) && (awAddr_q <= OFS_IRQ);
   assign wrOk     = doWrite & wrMapped & wLane_q;
   assign wb       = wByte_q;

   function automatic logic hit(input logic [ADDR_W-1:0] ofs);
      hit = wrOk && (awAddr_q == ofs);
   endfunction : hit

   logic wrCon;
   logic wrClk;
   logic wrIncL;
   logic wrIncH;
   logic polChange;

   assign wrCon  = hit(OFS_CONTROL);
   assign wrClk  = hit(OFS_CLOCK_SEL);
   assign wrIncL = hit(OFS_INC_LOW);
   assign wrIncH = hit(OFS_INC_HIGH);
   assign polChange = wrCon && (wb[CON_POL_BIT] != ctrl_q.outputInvert);

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_q   <= '0;
         clkCfg_q <= '0;
      end else begin
         if (wrCon) begin
            ctrl_q.moduleOn        <= wb[CON_ON_BIT];
            ctrl_q.pinDriveEnable  <= wb[CON_OE_BIT];
            ctrl_q.outputInvert    <= wb[CON_POL_BIT];
            ctrl_q.pulseModeSelect <= wb[CON_PFM_BIT];
         end
         if (wrClk) begin
            clkCfg_q.pulseWidthSelect <=
               wb[CLK_PWS_LSB +: PWS_W];
            clkCfg_q.inputClockSelect <=
               clk_src_t'(wb[CLK_CKS_LSB +: 2]);
         end
      end
   end

   // ----------------------------------------------------------------
   // Accumulator
   // ----------------------------------------------------------------
   // A software write wins over an addition in the same cycle; the
   // byte written is what software sees next, with no half-sum mixed in.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         accumulatorValue_q <= '0;
      end else if (hit(OFS_ACC_LOW)) begin
         accumulatorValue_q[7:0] <= wb;
      end else if (hit(OFS_ACC_HIGH)) begin
         accumulatorValue_q[15:8] <= wb;
      end else if (hit(OFS_ACC_UPPER)) begin
         accumulatorValue_q[ACC_W-1:INC_W] <= wb[ACCU_W-1:0];
      end else if (step) begin
         accumulatorValue_q <= sum[ACC_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Increment registers and hidden buffer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         incrementValue_q <= '0;
      end else begin
         if (wrIncL) begin
            incrementValue_q[7:0] <= wb;
         end
         if (wrIncH) begin
            incrementValue_q[15:8] <= wb;
         end
      end
   end

   // The buffer copies the whole increment at once, so the adder never
   // sees a half-written value while the module runs.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         incBuf_q   <= '0;
         loadWait_q <= '0;
         loadNow_q  <= 1'b0;
      end else begin
         loadNow_q <= (wrIncL | wrIncH) & ~ctrl_q.moduleOn;
         if (wrIncL && ctrl_q.moduleOn) begin
            loadWait_q <= INC_LOAD_EDGES;
         end else if (step && loadWait_q != 2'h0) begin
            loadWait_q <= loadWait_q - 2'h1;
         end
         if (loadNow_q) begin
            incBuf_q <= incrementValue_q;
         end else if (step && loadWait_q == 2'h1) begin
            incBuf_q <= incrementValue_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Output shaping
   // ----------------------------------------------------------------
   logic [PCNT_W-1:0] widthLast;
   logic              rawOut;
   logic              levelNext;

   assign widthLast = PCNT_W'((9'h001 << clkCfg_q.pulseWidthSelect)
                              - 9'h001);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         toggleOut_q <= 1'b0;
      end else if (accumulatorCarry) begin
         toggleOut_q <= ~toggleOut_q;
      end
   end

   // An overflow during an active pulse restarts it; software keeps the
   // width below the overflow period, otherwise the pulse never ends and the output stays active.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pulseActive_q <= 1'b0;
         pulseCnt_q    <= '0;
      end else if (accumulatorCarry) begin
         pulseActive_q <= 1'b1;
         pulseCnt_q    <= widthLast;
      end else if (step && pulseActive_q) begin
         if (pulseCnt_q == '0) begin
            pulseActive_q <= 1'b0;
         end else begin
            pulseCnt_q <= pulseCnt_q - PCNT_W'(1);
         end
      end
   end

   assign rawOut = ctrl_q.pulseModeSelect ? pulseActive_q
                                          : toggleOut_q;
   assign levelNext = rawOut ^ ctrl_q.outputInvert;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         outputLevel_q <= 1'b0;
         oscOutput     <= 1'b0;
         pinOut        <= 1'b0;
         pinOutEnable  <= 1'b0;
         keepFastOscOn <= 1'b0;
      end else begin
         outputLevel_q <= levelNext;
         oscOutput     <= levelNext;
         pinOut        <= levelNext;
         pinOutEnable  <= ctrl_q.pinDriveEnable;
         keepFastOscOn <= ctrl_q.moduleOn &&
            (clkCfg_q.inputClockSelect == CK_FAST_OSC);
      end
   end

   // ----------------------------------------------------------------
   // Interrupt flag and request
   // ----------------------------------------------------------------
   logic flagSet;

   assign flagSet = accumulatorCarry
                  | (polChange & overflowIrqEnable_q);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         overflowIrqFlag_q   <= 1'b0;
         overflowIrqEnable_q <= 1'b0;
      end else begin
         if (flagSet) begin
            overflowIrqFlag_q <= 1'b1;
         end else if (hit(OFS_IRQ)) begin
            overflowIrqFlag_q <= wb[IRQ_FLAG_BIT];
         end
         if (hit(OFS_IRQ)) begin
            overflowIrqEnable_q <= wb[IRQ_EN_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irqRequest <= 1'b0;
      end else begin
         irqRequest <= overflowIrqFlag_q & ctrl_q.moduleOn
                     & overflowIrqEnable_q & peripheralIrqEnable
                     & globalIrqEnable;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channels
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         awAddr_q <= '0;
         awHeld_q <= 1'b0;
         awready  <= 1'b1;
         wByte_q  <= '0;
         wLane_q  <= 1'b0;
         wHeld_q  <= 1'b0;
         wready   <= 1'b1;
         bvalid   <= 1'b0;
         bresp    <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awAddr_q <= awaddr;
            awHeld_q <= 1'b1;
            awready  <= 1'b0;
         end
         if (wvalid && wready) begin
            wByte_q <= wdata[BYTE_W-1:0];
            wLane_q <= wstrb[0];
            wHeld_q <= 1'b1;
            wready  <= 1'b0;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channels
   // ----------------------------------------------------------------
   logic              rdMapped;
   logic [BYTE_W-1:0] rdByte;

   assign rdMapped = (araddr[1:0] == 2'h0) && (araddr <= OFS_IRQ);

   always_comb begin
      rdByte = REG_RESET;
      unique case (araddr)
         OFS_CONTROL: begin
            rdByte[CON_ON_BIT]  = ctrl_q.moduleOn;
            rdByte[CON_OE_BIT]  = ctrl_q.pinDriveEnable;
            rdByte[CON_OUT_BIT] = outputLevel_q;
            rdByte[CON_POL_BIT] = ctrl_q.outputInvert;
            rdByte[CON_PFM_BIT] = ctrl_q.pulseModeSelect;
         end
         OFS_CLOCK_SEL: begin
            rdByte[CLK_PWS_LSB +: PWS_W] = clkCfg_q.pulseWidthSelect;
            rdByte[CLK_CKS_LSB +: 2]     = clkCfg_q.inputClockSelect;
         end
         OFS_ACC_LOW:   rdByte = accumulatorValue_q[7:0];
         OFS_ACC_HIGH:  rdByte = accumulatorValue_q[15:8];
         OFS_ACC_UPPER: begin
            rdByte[ACCU_W-1:0] =
               accumulatorValue_q[ACC_W-1:INC_W];
         end
         OFS_INC_LOW:   rdByte = incrementValue_q[7:0];
         OFS_INC_HIGH:  rdByte = incrementValue_q[15:8];
         OFS_IRQ: begin
            rdByte[IRQ_FLAG_BIT] = overflowIrqFlag_q;
            rdByte[IRQ_EN_BIT]   = overflowIrqEnable_q;
         end
         default:       rdByte = REG_RESET;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= DATA_W'(rdByte);
         rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule : numeric_oscillator

`default_nettype wire

// ---- numeric_oscillator_test.sv ----
// Self-checking bench for the numeric oscillator over AXI4-Lite.
// Source clocks run at one eighth of clk_sys to stay below the sync limit.
`timescale 1ns/1ns
`default_nettype none
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin \
   n_errors++; $display("Error %s exp %0h got %0h", w, e, g); end end

module numeric_oscillator_test;
   import nco_pkg::*;
   logic        clk_sys = 1'b0, rst = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, v;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        peripheralIrqEnable = 0, globalIrqEnable = 0;
   logic [2:0]  srcCnt = 3'h0;
   logic [1:0]  r, bresp, rresp;
   logic [31:0] rdata;
   logic        awready, wready, bvalid, arready, rvalid, oscOutput, pinOut;
   logic        pinOutEnable, irqRequest, keepFastOscOn, pinLevel;
   logic [15:0] riseCnt, periodQ, highQ;
   wire         internalFastOsc = srcCnt[2];
   wire         logicCell1Output = srcCnt[2];
   wire         externalClockPin = ~srcCnt[2];
   int          n_errors = 0, n_compared = 0;

   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) srcCnt <= srcCnt + 3'h1;

   numeric_oscillator u_dut (.clk_sys, .rst, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .internalFastOsc,
      .logicCell1Output, .externalClockPin, .peripheralIrqEnable,
      .globalIrqEnable, .oscOutput, .pinOut, .pinOutEnable, .irqRequest,
      .keepFastOscOn);
   nco_sink u_far (.clk_sys, .rst, .oscOutput, .pinOut, .pinOutEnable,
      .riseCnt, .periodQ, .highQ, .pinLevel);

   task end_sim;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   task automatic timeout;
      n_errors++;
      $display("Error wait exp done got timeout");
      end_sim();
   endtask : timeout

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int i;
      logic done;
      done = 0;
      @(posedge clk_sys);
      awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (i = 0; i < 50 && !done; i++) begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin done = 1; r = bresp; end
      end
      if (!done) timeout();
      bready <= 1'b0;
      `CHK("bresp", (a > OFS_IRQ) ? RESP_SLVERR : RESP_OKAY, r)
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      int i;
      logic done;
      done = 0;
      @(posedge clk_sys);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (i = 0; i < 50 && !done; i++) begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin done = 1; v = rdata[7:0]; r = rresp; end
      end
      if (!done) timeout();
      rready <= 1'b0;
      `CHK("rresp", (a > OFS_IRQ) ? RESP_SLVERR : RESP_OKAY, r)
      `CHK($sformatf("reg %h", a), e, v)
   endtask : rc

   // Skips the disturbed cycle after a setting change before measuring.
   task automatic settle;
      int i;
      logic [15:0] c;
      c = riseCnt;
      for (i = 0; i < 4000 && riseCnt - c < 16'h3; i++) @(posedge clk_sys);
      if (i == 4000) timeout();
   endtask : settle

   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      for (int a = 0; a <= 32; a += 4) rc(8'(a), 8'h00);
      wr(8'h24, 8'h55);
      wr(OFS_CLOCK_SEL, 8'hFF);
      rc(OFS_CLOCK_SEL, 8'hE3);
      wr(OFS_ACC_UPPER, 8'hFF);
      rc(OFS_ACC_UPPER, 8'h0F);
      wr(OFS_ACC_HIGH, 8'h34);
      rc(OFS_ACC_HIGH, 8'h34);
      wr(OFS_INC_HIGH, 8'hAB);
      rc(OFS_INC_HIGH, 8'hAB);
      $display("test registers done");
      wr(OFS_CONTROL, 8'h1E);
      rc(OFS_CONTROL, 8'h30);
      rc(OFS_IRQ, 8'h00);
      wr(OFS_IRQ, 8'h02);
      wr(OFS_CONTROL, 8'h00);
      rc(OFS_IRQ, 8'h03);
      wr(OFS_IRQ, 8'h00);
      $display("test polarity done");
      wr(OFS_INC_HIGH, 8'h80);
      wr(OFS_INC_LOW, 8'h00);
      wr(OFS_CLOCK_SEL, 8'h01);
      wr(OFS_CONTROL, 8'hC0);
      settle();
      `CHK("period", 16'h0040, periodQ)
      `CHK("high", 16'h0020, highQ)
      `CHK("pin enable", 1'b1, pinOutEnable)
      `CHK("pin level", oscOutput, pinLevel)
      rc(OFS_IRQ, 8'h01);
      wr(OFS_IRQ, 8'h02);
      peripheralIrqEnable <= 1'b1;
      repeat (100) @(posedge clk_sys);
      `CHK("irq", 1'b0, irqRequest)
      globalIrqEnable <= 1'b1;
      repeat (100) @(posedge clk_sys);
      `CHK("irq", 1'b1, irqRequest)
      rc(OFS_IRQ, 8'h03);
      globalIrqEnable <= 1'b0;
      wr(OFS_INC_HIGH, 8'h40);
      wr(OFS_INC_LOW, 8'h00);
      settle();
      `CHK("period", 16'h0080, periodQ)
      $display("test toggle done");
      wr(OFS_INC_HIGH, 8'h10);
      wr(OFS_INC_LOW, 8'h00);
      wr(OFS_CONTROL, 8'hC1);
      for (int p = 0; p < 8; p++) begin
         wr(OFS_CLOCK_SEL, {3'(p), 5'h01});
         settle();
         `CHK("period", 16'h0100, periodQ)
         `CHK("high", 16'(1 << p), highQ)
      end
      wr(OFS_CLOCK_SEL, 8'h41);
      wr(OFS_CONTROL, 8'hD1);
      settle();
      `CHK("high", 16'h00FC, highQ)
      $display("test pulse done");
      wr(OFS_CONTROL, 8'h80);
      wr(OFS_INC_HIGH, 8'h80);
      wr(OFS_INC_LOW, 8'h00);
      for (int c = 0; c < 4; c++) if (c != 1) begin
         wr(OFS_CLOCK_SEL, 8'(c));
         settle();
         `CHK("period", 16'h0200, periodQ)
         `CHK("keep osc", c == 0, keepFastOscOn)
      end
      `CHK("pin off", 1'b0, pinOutEnable)
      $display("test sources done");
      end_sim();
   end
endmodule : numeric_oscillator_test

bind numeric_oscillator nco_props u_props (.clk_sys, .rst, .awready,
   .wready, .bvalid, .bready, .arready, .rvalid, .rready, .rdata,
   .oscOutput, .pinOut, .irqRequest, .peripheralIrqEnable,
   .globalIrqEnable);

`default_nettype wire
